// *** rtl/tnco_consts.vh ***
// tnco_consts.vh: constants for the timing oscillator control block
// assumes inclusion by bare name from rtl/ design files
`ifndef TNCO_CONSTS_VH
`define TNCO_CONSTS_VH

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define TNCO_ADDR_W 5
`define TNCO_ADDR_CONFIG 5'h0b
`define TNCO_ADDR_FREQ_HOLD 5'h0c
`define TNCO_ADDR_PHASE_HOLD 5'h0d
`define TNCO_ADDR_FREQ_STROBE 5'h0e
`define TNCO_ADDR_PHASE_STROBE 5'h0f
`define TNCO_ADDR_FREQ_ACTIVE 5'h10
`define TNCO_ADDR_PHASE_ACTIVE 5'h11
`define TNCO_ADDR_ACC_PHASE 5'h12
`define TNCO_ADDR_SYNC_COUNT 5'h13

// ----------------------------------------------------------------
// configuration field positions
// ----------------------------------------------------------------
`define TNCO_CFG_LOAD_ZERO_BIT 0
`define TNCO_CFG_CLR_ACC_BIT 1
`define TNCO_CFG_OFS_EN_BIT 2
`define TNCO_CFG_OFS_WIDTH_LSB 3
`define TNCO_CFG_OFS_WIDTH_MSB 4
`define TNCO_CFG_SYNC_EN_BIT 5
`define TNCO_CFG_W 6

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define TNCO_DATA_W 32
`define TNCO_FREQ_W 32
`define TNCO_PHASE_W 8
`define TNCO_SYNC_CNT_W 16
`define TNCO_CFG_RST 6'h00
`define TNCO_FREQ_RST 32'h00000000
`define TNCO_PHASE_RST 8'h00
`define TNCO_SYNC_CNT_RST 16'h0000

`endif

// *** rtl/tnco_sync_edge.v ***
// tnco_sync_edge.v: assertion detector for the external sync pin
// assumes the pin is synchronous to the processing clock
`timescale 1ns/10ps
module tnco_sync_edge (
    // clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // pin and result
    input wire sync_i,
    output wire rise_o
);

    reg level_q;
    reg rise_q;

    // ----------------------------------------------------------------
    // sample and detect one pulse per assertion
    // ----------------------------------------------------------------
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            level_q <= sync_i; // R16
            rise_q <= sync_i & ~level_q; // R16
        end
    end

    assign rise_o = rise_q;

endmodule // tnco_sync_edge

// *** rtl/tnco_phase_acc.v ***
// tnco_phase_acc.v: phase accumulator with offset adder
// assumes one-cycle sample strobes and control from the top module
`timescale 1ns/10ps
module tnco_phase_acc #(
    parameter ACC_W = 32,
    parameter OFS_W = 8
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // control
    input wire sample_i,
    input wire [ACC_W-1:0] inc_i,
    input wire clr_fb_i,
    input wire zero_i,
    input wire [OFS_W-1:0] phase_ofs_i,
    // results
    output wire [ACC_W-1:0] acc_o,
    output wire [ACC_W-1:0] phase_o
);

    reg [ACC_W-1:0] acc_q;
    reg [ACC_W-1:0] phase_q;
    wire [ACC_W-1:0] fb;
    wire [ACC_W-1:0] acc_sum;

    // ----------------------------------------------------------------
    // feedback path and accumulation
    // ----------------------------------------------------------------
    assign fb = clr_fb_i ? {ACC_W{1'b0}} : acc_q; // R5
    assign acc_sum = fb + inc_i; // R15

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_q <= {ACC_W{1'b0}};
            phase_q <= {ACC_W{1'b0}};
        end else begin
            if (zero_i) begin
                acc_q <= {ACC_W{1'b0}}; // R3 R6
            end else if (sample_i) begin
                acc_q <= acc_sum; // R15
            end
            phase_q <= acc_q + {phase_ofs_i, {(ACC_W-OFS_W){1'b0}}}; // R15
        end
    end

    assign acc_o = acc_q;
    assign phase_o = phase_q;

endmodule // tnco_phase_acc

// *** rtl/tnco_ctrl.v ***
// tnco_ctrl.v: timing oscillator control, holding and active registers
// assumes a plain register port and pins synchronous to core_clk_i
//
// Overview of operation
// R1: sync enable clear means the external sync pin is ignored.
// R2: enabled sync assertion copies both holding registers into active registers.
// R3: enabled sync with load-on-update set also zeroes accumulator feedback.
// R4: offset enable clear presents zero offset; set passes offset frequency through.
// R5: clear-accumulator bit set forces accumulator feedback to zero.
// R6: load-on-update set: frequency strobe zeroes feedback while updating active values.
// R7: center frequency is a 32-bit word, bit 31 the MSB.
// R8: center frequency write loads holding only; active changes on strobe or sync.
// R9: phase offset is an 8-bit field, bit 7 the MSB.
// R10: phase offset write loads holding only; active changes on strobe or sync.
// R11: any write to frequency strobe copies held frequency to active.
// R12: any write to phase strobe copies held phase offset to active.
// R13: all configuration and strobe effects run on the processing clock.
// R14: configuration bits 31 to 6 are reserved and have no effect.
// R15: each sample adds active frequency plus gated offset; phase offset added after.
// R16: sync pin sampled on processing clock; one transfer per assertion when enabled.
`timescale 1ns/10ps
`include "tnco_consts.vh"
module tnco_ctrl #(
    parameter FREQ_W = 32,
    parameter PHASE_W = 8,
    parameter SYNC_CNT_W = 16
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // register port
    input wire [`TNCO_ADDR_W-1:0] reg_addr_i,
    input wire [`TNCO_DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [`TNCO_DATA_W-1:0] reg_rdata_o,
    // external sync pin
    input wire external_sync_input_i,
    // datapath side
    input wire resamp_sample_i,
    input wire [FREQ_W-1:0] offset_freq_i,
    // oscillator state
    output wire [FREQ_W-1:0] nco_phase_o,
    output wire [FREQ_W-1:0] nco_acc_o,
    output wire [FREQ_W-1:0] active_freq_o,
    output wire [PHASE_W-1:0] active_phase_o,
    // configuration and load pulse out
    output wire [1:0] ofs_width_o,
    output wire ofs_en_o,
    output wire transfer_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg [`TNCO_CFG_W-1:0] cfg_q;
    reg [`TNCO_CFG_W-1:0] cfg_d;
    reg [FREQ_W-1:0] freq_hold_q;
    reg [FREQ_W-1:0] freq_hold_d;
    reg [PHASE_W-1:0] phase_hold_q;
    reg [PHASE_W-1:0] phase_hold_d;
    reg [FREQ_W-1:0] freq_act_q;
    reg [FREQ_W-1:0] freq_act_d;
    reg [PHASE_W-1:0] phase_act_q;
    reg [PHASE_W-1:0] phase_act_d;
    reg [SYNC_CNT_W-1:0] sync_cnt_q;
    reg [SYNC_CNT_W-1:0] sync_cnt_d;
    reg [`TNCO_DATA_W-1:0] rdata_q;
    reg [`TNCO_DATA_W-1:0] rdata_d;
    reg transfer_q;
    reg transfer_d;
    reg zero_q;
    reg zero_d;
    reg [FREQ_W-1:0] ofs_gated;
    reg [`TNCO_DATA_W-1:0] rd_mux;

    wire wr_cfg;
    wire wr_freq_hold;
    wire wr_phase_hold;
    wire wr_freq_strobe;
    wire wr_phase_strobe;
    wire sync_rise;
    wire sync_xfer;
    wire freq_load;
    wire phase_load;
    wire sync_en;
    wire load_zero;
    wire clr_acc;
    wire [FREQ_W-1:0] inc;
    wire [FREQ_W-1:0] acc_val;
    wire [FREQ_W-1:0] phase_val;

    // ----------------------------------------------------------------
    // configuration field decode
    // ----------------------------------------------------------------
    assign sync_en = cfg_q[`TNCO_CFG_SYNC_EN_BIT];
    assign load_zero = cfg_q[`TNCO_CFG_LOAD_ZERO_BIT];
    assign clr_acc = cfg_q[`TNCO_CFG_CLR_ACC_BIT];

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign wr_cfg = reg_wr_i && (reg_addr_i == `TNCO_ADDR_CONFIG);
    assign wr_freq_hold = reg_wr_i && (reg_addr_i == `TNCO_ADDR_FREQ_HOLD);
    assign wr_phase_hold = reg_wr_i && (reg_addr_i == `TNCO_ADDR_PHASE_HOLD);
    assign wr_freq_strobe = reg_wr_i && (reg_addr_i == `TNCO_ADDR_FREQ_STROBE); // R11
    assign wr_phase_strobe = reg_wr_i && (reg_addr_i == `TNCO_ADDR_PHASE_STROBE); // R12

    // ----------------------------------------------------------------
    // external sync detection
    // ----------------------------------------------------------------
    tnco_sync_edge u_sync (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .sync_i(external_sync_input_i),
        .rise_o(sync_rise)
    );

    assign sync_xfer = sync_rise & sync_en; // R1 R16
    assign freq_load = wr_freq_strobe | sync_xfer; // R2 R11
    assign phase_load = wr_phase_strobe | sync_xfer; // R2 R12

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    always @* begin
        cfg_d = cfg_q;
        if (wr_cfg) begin
            cfg_d = reg_wdata_i[`TNCO_CFG_W-1:0]; // R14
        end
    end

    // ----------------------------------------------------------------
    // holding registers
    // ----------------------------------------------------------------
    always @* begin
        freq_hold_d = freq_hold_q;
        if (wr_freq_hold) begin
            freq_hold_d = reg_wdata_i[FREQ_W-1:0]; // R7 R8
        end
    end

    always @* begin
        phase_hold_d = phase_hold_q;
        if (wr_phase_hold) begin
            phase_hold_d = reg_wdata_i[PHASE_W-1:0]; // R9 R10
        end
    end

    // ----------------------------------------------------------------
    // active registers
    // ----------------------------------------------------------------
    always @* begin
        freq_act_d = freq_act_q;
        if (freq_load) begin
            freq_act_d = freq_hold_q; // R8 R11
        end
    end

    always @* begin
        phase_act_d = phase_act_q;
        if (phase_load) begin
            phase_act_d = phase_hold_q; // R10 R12
        end
    end

    // ----------------------------------------------------------------
    // feedback zeroing on update
    // ----------------------------------------------------------------
    always @* begin
        zero_d = 1'b0;
        if (load_zero && (wr_freq_strobe || sync_xfer)) begin
            zero_d = 1'b1; // R3 R6
        end
    end

    // ----------------------------------------------------------------
    // sync transfer counter
    // ----------------------------------------------------------------
    always @* begin
        sync_cnt_d = sync_cnt_q;
        if (sync_xfer) begin
            sync_cnt_d = sync_cnt_q + {{(SYNC_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always @* begin
        rd_mux = {`TNCO_DATA_W{1'b0}};
        case (reg_addr_i)
            `TNCO_ADDR_CONFIG: begin
                rd_mux[`TNCO_CFG_W-1:0] = cfg_q; // R14
            end
            `TNCO_ADDR_FREQ_HOLD: begin
                rd_mux[FREQ_W-1:0] = freq_hold_q;
            end
            `TNCO_ADDR_PHASE_HOLD: begin
                rd_mux[PHASE_W-1:0] = phase_hold_q;
            end
            `TNCO_ADDR_FREQ_ACTIVE: begin
                rd_mux[FREQ_W-1:0] = freq_act_q;
            end
            `TNCO_ADDR_PHASE_ACTIVE: begin
                rd_mux[PHASE_W-1:0] = phase_act_q;
            end
            `TNCO_ADDR_ACC_PHASE: begin
                rd_mux[FREQ_W-1:0] = acc_val;
            end
            `TNCO_ADDR_SYNC_COUNT: begin
                rd_mux[SYNC_CNT_W-1:0] = sync_cnt_q;
            end
            default: begin
                rd_mux = {`TNCO_DATA_W{1'b0}};
            end
        endcase
    end

    always @* begin
        rdata_d = {`TNCO_DATA_W{1'b0}};
        if (reg_rd_i) begin
            rdata_d = rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // offset frequency gating
    // ----------------------------------------------------------------
    always @* begin
        ofs_gated = {FREQ_W{1'b0}}; // R4
        if (cfg_q[`TNCO_CFG_OFS_EN_BIT]) begin
            ofs_gated = offset_freq_i; // R4
        end
    end

    assign inc = freq_act_q + ofs_gated; // R15

    // ----------------------------------------------------------------
    // load pulse
    // ----------------------------------------------------------------
    always @* begin
        transfer_d = freq_load | phase_load;
    end

    // ----------------------------------------------------------------
    // state registers, all on the processing clock
    // ----------------------------------------------------------------
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_q <= `TNCO_CFG_RST;
        end else begin
            cfg_q <= cfg_d; // R13
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            freq_hold_q <= `TNCO_FREQ_RST;
        end else begin
            freq_hold_q <= freq_hold_d; // R13
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_hold_q <= `TNCO_PHASE_RST;
        end else begin
            phase_hold_q <= phase_hold_d; // R13
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            freq_act_q <= `TNCO_FREQ_RST;
        end else begin
            freq_act_q <= freq_act_d; // R13
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_act_q <= `TNCO_PHASE_RST;
        end else begin
            phase_act_q <= phase_act_d; // R13
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_cnt_q <= `TNCO_SYNC_CNT_RST;
        end else begin
            sync_cnt_q <= sync_cnt_d;
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= {`TNCO_DATA_W{1'b0}};
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            transfer_q <= 1'b0;
        end else begin
            transfer_q <= transfer_d;
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            zero_q <= 1'b0;
        end else begin
            zero_q <= zero_d;
        end
    end

    // ----------------------------------------------------------------
    // phase accumulator
    // ----------------------------------------------------------------
    tnco_phase_acc #(
        .ACC_W(FREQ_W),
        .OFS_W(PHASE_W)
    ) u_acc (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .sample_i(resamp_sample_i),
        .inc_i(inc),
        .clr_fb_i(clr_acc), // R5
        .zero_i(zero_q),
        .phase_ofs_i(phase_act_q),
        .acc_o(acc_val),
        .phase_o(phase_val)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o = rdata_q;
    assign nco_phase_o = phase_val;
    assign nco_acc_o = acc_val;
    assign active_freq_o = freq_act_q;
    assign active_phase_o = phase_act_q;
    assign ofs_width_o = cfg_q[`TNCO_CFG_OFS_WIDTH_MSB:`TNCO_CFG_OFS_WIDTH_LSB];
    assign ofs_en_o = cfg_q[`TNCO_CFG_OFS_EN_BIT];
    assign transfer_o = transfer_q;

endmodule // tnco_ctrl

// *** test/tnco_ctrl_checker.sv ***
// tnco_ctrl_checker.sv: port assertions for the oscillator control
// assumes bind to tnco_ctrl with default widths
`timescale 1ns/10ps
module tnco_ctrl_checker (
    // clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // watched ports
    input wire [4:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire external_sync_input_i,
    input wire resamp_sample_i,
    input wire [31:0] offset_freq_i,
    input wire [31:0] nco_acc_o,
    input wire [31:0] active_freq_o,
    input wire [7:0] active_phase_o
);
    // ------------------------------------------------
    // shadow of written words
    // ------------------------------------------------
    logic [5:0] cfg_q;
    logic [31:0] fh_q;
    logic [7:0] ph_q;
    wire stbf = reg_wr_i && reg_addr_i == 5'h0e;
    wire stbp = reg_wr_i && reg_addr_i == 5'h0f;
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_q <= 6'h00;
            fh_q <= 32'h0;
            ph_q <= 8'h00;
        end else if (reg_wr_i) begin
            if (reg_addr_i == 5'h0b) cfg_q <= reg_wdata_i[5:0];
            if (reg_addr_i == 5'h0c) fh_q <= reg_wdata_i;
            if (reg_addr_i == 5'h0d) ph_q <= reg_wdata_i[7:0];
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_sync_on;
        $rose(external_sync_input_i) && cfg_q[5];
    endsequence
    sequence s_zero_stb;
        stbf && cfg_q[0];
    endsequence
    chk_freq_src: assert property ($changed(active_freq_o) |->
        $past(stbf) || ($past(external_sync_input_i, 2) && !$past(external_sync_input_i, 3)
        && $past(cfg_q[5])))
        else $error("active freq changed without a load");
    chk_phase_src: assert property ($changed(active_phase_o) |->
        $past(stbp) || ($past(external_sync_input_i, 2) && !$past(external_sync_input_i, 3)
        && $past(cfg_q[5])))
        else $error("active phase changed without a load");
    chk_freq_load: assert property (stbf |=> active_freq_o == fh_q)
        else $error("freq strobe did not load held freq");
    chk_phase_load: assert property (stbp |=> active_phase_o == ph_q)
        else $error("phase strobe did not load held phase");
    chk_sync_load: assert property (s_sync_on |-> ##2
        active_freq_o == fh_q && active_phase_o == ph_q)
        else $error("sync did not load both holding words");
    chk_acc_step: assert property (resamp_sample_i && !cfg_q[0] |=>
        nco_acc_o == ($past(cfg_q[1]) ? 32'h0 : $past(nco_acc_o)) + $past(active_freq_o)
        + ($past(cfg_q[2]) ? $past(offset_freq_i) : 32'h0))
        else $error("accumulator step wrong");
    chk_stb_zero: assert property (s_zero_stb |-> ##2 nco_acc_o == 32'h0)
        else $error("freq strobe did not zero accumulator");
    chk_sync_zero: assert property (s_sync_on ##0 cfg_q[0] |-> ##3 nco_acc_o == 32'h0)
        else $error("sync did not zero accumulator");
endmodule // tnco_ctrl_checker

bind tnco_ctrl tnco_ctrl_checker u_chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .external_sync_input_i(external_sync_input_i), .resamp_sample_i(resamp_sample_i),
    .offset_freq_i(offset_freq_i), .nco_acc_o(nco_acc_o), .active_freq_o(active_freq_o),
    .active_phase_o(active_phase_o)
);

// *** test/tnco_sync_src.sv ***
// tnco_sync_src.sv: model of the external sync source
// assumes requests from the bench on the processing clock
`timescale 1ns/10ps
module tnco_sync_src (
    // clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // request
    input wire fire_i,
    input wire [7:0] len_i,
    // pin
    output logic pin_o
);
    logic [7:0] cnt_q;
    // pin held high len_i cycles, then low
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 8'h00;
            pin_o <= 1'b0;
        end else begin
            cnt_q <= fire_i ? len_i : (cnt_q != 8'h00 ? cnt_q - 8'h01 : 8'h00);
            pin_o <= fire_i || cnt_q > 8'h01;
        end
    end
endmodule // tnco_sync_src

// *** test/test_timing_nco_control.sv ***
// test_timing_nco_control.sv: register-level tests of the oscillator control
// assumes tnco_ctrl, tnco_sync_src and the bound checker are compiled
`timescale 1ns/10ps
module test_timing_nco_control;
    logic core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, resamp_sample_i, fire;
    logic [4:0] reg_addr_i;
    logic [31:0] reg_wdata_i, offset_freq_i;
    logic [7:0] flen;
    wire [31:0] reg_rdata_o, nco_phase_o, nco_acc_o, active_freq_o;
    wire [7:0] active_phase_o;
    wire [1:0] ofs_width_o;
    wire ofs_en_o, transfer_o, sync_pin;
    int err_count, cmp_count;
    logic [4:0] ra [8] = '{5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h11, 5'h12, 5'h1f};
    tnco_ctrl uut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .external_sync_input_i(sync_pin),
        .resamp_sample_i(resamp_sample_i), .offset_freq_i(offset_freq_i),
        .nco_phase_o(nco_phase_o), .nco_acc_o(nco_acc_o), .active_freq_o(active_freq_o),
        .active_phase_o(active_phase_o), .ofs_width_o(ofs_width_o), .ofs_en_o(ofs_en_o),
        .transfer_o(transfer_o)
    );
    tnco_sync_src u_src (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .fire_i(fire), .len_i(flen),
        .pin_o(sync_pin)
    );
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task stop_test;
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 cmp(reg_rdata_o, exp);
    endtask
    task smp;
        @(posedge core_clk_i);
        resamp_sample_i <= 1'b1;
        @(posedge core_clk_i);
        resamp_sample_i <= 1'b0;
    endtask
    task sync(input logic [7:0] n);
        @(posedge core_clk_i);
        fire <= 1'b1;
        flen <= n;
        @(posedge core_clk_i);
        fire <= 1'b0;
        repeat (n + 6) @(posedge core_clk_i);
    endtask
    initial begin
        #20000;
        err_count++;
        stop_test;
    end
    initial begin
        err_count = 0;
        cmp_count = 0;
        {rst_b_i, reg_wr_i, reg_rd_i, resamp_sample_i, fire} = 5'h00;
        reg_addr_i = 5'h00;
        reg_wdata_i = 32'h0;
        flen = 8'h00;
        offset_freq_i = 32'h100;
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        foreach (ra[k]) rd(ra[k], 32'h0);
        wr(5'h0b, 32'hffffffc0);
        rd(5'h0b, 32'h0);
        wr(5'h0d, 32'habcdef5a);
        rd(5'h0d, 32'h5a);
        wr(5'h0c, 32'h89abcdef);
        rd(5'h0c, 32'h89abcdef);
        rd(5'h10, 32'h0);
        rd(5'h11, 32'h0);
        wr(5'h0e, 32'hdeadbeef);
        rd(5'h10, 32'h89abcdef);
        wr(5'h0f, 32'h0);
        #1 cmp({24'h0, active_phase_o}, 32'h5a);
        cmp({31'h0, transfer_o}, 32'h1);
        wr(5'h0c, 32'h11111111);
        wr(5'h0d, 32'h33);
        sync(8'h04);
        rd(5'h10, 32'h89abcdef);
        rd(5'h13, 32'h0);
        wr(5'h0b, 32'h20);
        sync(8'h0a);
        rd(5'h10, 32'h11111111);
        rd(5'h11, 32'h33);
        rd(5'h13, 32'h1);
        wr(5'h0b, 32'h06);
        smp;
        rd(5'h12, 32'h11111211);
        wr(5'h0b, 32'h1c);
        #1 cmp({30'h0, ofs_width_o}, 32'h3);
        cmp({31'h0, ofs_en_o}, 32'h1);
        smp;
        rd(5'h12, 32'h22222422);
        wr(5'h0b, 32'h00);
        #1 cmp({31'h0, ofs_en_o}, 32'h0);
        smp;
        rd(5'h12, 32'h33333533);
        wr(5'h0b, 32'h01);
        wr(5'h0c, 32'h40);
        wr(5'h0e, 32'h0);
        rd(5'h12, 32'h0);
        rd(5'h10, 32'h40);
        smp;
        rd(5'h12, 32'h40);
        wr(5'h0b, 32'h21);
        wr(5'h0c, 32'h80);
        sync(8'h02);
        rd(5'h12, 32'h0);
        rd(5'h10, 32'h80);
        cmp(nco_phase_o, 32'h33000000);
        stop_test;
    end
endmodule // test_timing_nco_control
